/* File: verilog/link_setup_pkg.sv */
package link_setup_pkg;
  // frequencies in MHz, lane rate in Mbps
  localparam int FREQ_W = 14;
  localparam int RATE_W = 18;
  localparam logic [FREQ_W-1:0] LO_BAND1_MIN = 14'd1500;
  localparam logic [FREQ_W-1:0] LO_BAND1_MAX = 14'd2250;
  localparam logic [FREQ_W-1:0] LO_BAND2_MIN = 14'd750;
  localparam logic [FREQ_W-1:0] LO_BAND3_MIN = 14'd420;
  localparam logic [FREQ_W-1:0] REF_BAND1_MIN = 14'd80;
  localparam logic [FREQ_W-1:0] REF_BAND2_MIN = 14'd160;
  localparam logic [FREQ_W-1:0] REF_BAND3_MIN = 14'd320;
  localparam logic [FREQ_W-1:0] REF_BAND4_MIN = 14'd640;
  localparam logic [FREQ_W-1:0] REF_BAND4_MAX = 14'd1000;
  localparam logic [FREQ_W-1:0] VCO_MIN = 14'd6000;
  localparam logic [FREQ_W-1:0] VCO_MAX = 14'd12000;
  localparam logic [7:0] FB_MIN = 8'd6;
  localparam logic [7:0] FB_MAX = 8'd127;
  localparam logic [RATE_W-1:0] LANE_MIN = 18'd1440;
  localparam logic [RATE_W-1:0] LANE_MAX = 18'd12380;
  localparam logic [RATE_W-1:0] CDR_BAND1_MAX = 18'd3090;
  localparam logic [RATE_W-1:0] CDR_BAND2_MAX = 18'd6190;
  localparam logic [4:0] SAMPLE_BITS = 5'd16;
  localparam logic [5:0] K_LONG = 6'd32;
  localparam logic [5:0] K_SHORT = 6'd16;
  localparam logic [4:0] LANE_RATE_MUL = 5'd20;
  localparam logic [3:0] PHYS_LANES = 4'd4;
  localparam logic [11:0] CFG_REG_FIRST = 12'h450;
  localparam logic [11:0] CFG_REG_LAST = 12'h45a;
  localparam logic [2:0] LINK_VERSION_RESET = 3'd1;
  // register map
  localparam logic [11:0] OUT_DIV_ADDR = 12'h08b;
  localparam logic [11:0] REF_DIV_ADDR = 12'h08c;
  localparam logic [11:0] LANE_OFF_ADDR = 12'h201;
  localparam logic [11:0] SERDES_PLL_ADDR = 12'h289;
  localparam logic [11:0] CTRL_ADDR = 12'h800;
  localparam logic [11:0] STATUS_ADDR = 12'h801;
  localparam logic [11:0] FREQ_DAC_ADDR = 12'h802;
  localparam logic [11:0] FREQ_REF_ADDR = 12'h803;
  localparam logic [11:0] LINK_ADDR = 12'h804;
  localparam logic [11:0] FEEDBACK_ADDR = 12'h805;
  localparam logic [11:0] PARAMS_ADDR = 12'h806;
  localparam logic [11:0] CHECKSUM_ADDR = 12'h807;
  localparam logic [11:0] POWER_ADDR = 12'h808;
  localparam logic [11:0] LANES_ADDR = 12'h809;
  localparam logic [7:0] SERDES_PLL_FIXED = 8'h04;
  localparam int CALC_CYCLES = 24;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] lo_sel;
    logic [2:0] ref_sel;
    logic [7:0] feedback;
    logic [1:0] interp;
    logic [3:0] lane_en;
    logic [3:0] lane_off;
    logic [7:0] checksum;
    logic [1:0] conv_pd;
    logic [1:0] clk_pd;
    logic cdr_rate;
    logic cdr_ovs;
    logic [1:0] pll_div;
    logic hd;
    logic [5:0] k;
    logic [3:0] m;
    logic [3:0] l;
    logic [3:0] s;
    logic [3:0] f;
  } setup_t;
endpackage : link_setup_pkg

/* File: verilog/dac_link_setup_calc.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// - output divider code from converter rate band
// - reference divider code and factor from reference
// - oscillator is rate times two-power, 6-12 GHz
// - feedback count floor division, valid 6..127
// - interpolation codes 0..3 give 1,2,4,8
// - only modes 4,5,6,7,9,10 with table M,L,S,F
// - lane rate 20*data*M/L, 1.44-12.38 Gbps
// - HD is one exactly when F is one
// - N, Np 16; K 32 in modes 4, 9
// - scrambling flag follows scrambled data
// - link index fixed at zero
// - lane enable is 2^L minus one
// - unused physical lanes powered off by mask
// - checksum method matches transmitter; fields or registers
// - method zero sums fields, low eight bits
// - method one sums registers 0x450..0x45a
// - converter power-down from M and kept converter
// - clock power-down of idle converter
// - CDR settings from lane rate band
// - pll divide in low two bits of register
module dac_link_setup_calc (
  input wire logic mclk,
  input wire logic rst,
  input wire link_setup_pkg::reg_req_t req,
  output logic [31:0] rdata,
  output logic done,
  output logic cfg_error,
  output link_setup_pkg::setup_t setup
);
  import link_setup_pkg::*;

  // ----------------------------------------
  // software settings
  // ----------------------------------------
  logic [FREQ_W-1:0] dac_mhz_r;
  logic [FREQ_W-1:0] ref_mhz_r;
  logic [3:0] mode_r;
  logic [1:0] interp_r;
  logic k_short_r;
  logic scramble_r;
  logic subclass_r;
  logic checksum_method_r;
  logic keep_q_r;
  logic [2:0] version_r;
  logic [3:0] phys_map_r;
  logic start;

  assign start = req.wr && req.addr == CTRL_ADDR && req.wdata[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      dac_mhz_r <= '0;
      ref_mhz_r <= '0;
      mode_r <= 4'd4;
      interp_r <= 2'd0;
      k_short_r <= 1'b0;
      scramble_r <= 1'b0;
      subclass_r <= 1'b0;
      checksum_method_r <= 1'b0;
      keep_q_r <= 1'b0;
      version_r <= LINK_VERSION_RESET;
      phys_map_r <= 4'h0;
    end else if (req.wr) begin
      unique case (req.addr)
        FREQ_DAC_ADDR: dac_mhz_r <= req.wdata[FREQ_W-1:0];
        FREQ_REF_ADDR: ref_mhz_r <= req.wdata[FREQ_W-1:0];
        LINK_ADDR: begin
          mode_r <= req.wdata[3:0];
          interp_r <= req.wdata[5:4];
          k_short_r <= req.wdata[6];
          scramble_r <= req.wdata[7];
          subclass_r <= req.wdata[8];
          checksum_method_r <= req.wdata[9];
          keep_q_r <= req.wdata[10];
          version_r <= req.wdata[13:11];
          phys_map_r <= req.wdata[19:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // mode table
  // ----------------------------------------
  logic mode_ok;
  logic [3:0] m_v;
  logic [3:0] l_v;
  logic [3:0] s_v;
  logic [3:0] f_v;

  always_comb begin
    mode_ok = 1'b1;
    m_v = 4'd2;
    l_v = 4'd4;
    s_v = 4'd1;
    f_v = 4'd1;
    unique case (mode_r)
      4'd4: begin l_v = 4'd4; end
      4'd5: begin s_v = 4'd2; f_v = 4'd2; end
      4'd6: begin l_v = 4'd2; f_v = 4'd2; end
      4'd7: begin l_v = 4'd1; f_v = 4'd4; end
      4'd9: begin m_v = 4'd1; l_v = 4'd2; end
      4'd10: begin m_v = 4'd1; l_v = 4'd1; f_v = 4'd2; end
      default: mode_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // derivation
  // ----------------------------------------
  logic [2:0] lo_sel;
  logic [2:0] ref_sel;
  logic band_ok;
  logic [FREQ_W+3:0] vco;
  logic [RATE_W+7:0] lane_prod;
  logic [RATE_W+7:0] lane_rate;
  logic [5:0] k_v;
  logic k_ok;
  logic hd_v;

  always_comb begin
    band_ok = 1'b1;
    lo_sel = 3'd0;
    if (dac_mhz_r >= LO_BAND1_MIN && dac_mhz_r <= LO_BAND1_MAX) lo_sel = 3'd1;
    else if (dac_mhz_r >= LO_BAND2_MIN && dac_mhz_r < LO_BAND1_MIN) lo_sel = 3'd2;
    else if (dac_mhz_r >= LO_BAND3_MIN && dac_mhz_r < LO_BAND2_MIN) lo_sel = 3'd3;
    else band_ok = 1'b0;
    ref_sel = 3'd0;
    if (ref_mhz_r >= REF_BAND1_MIN && ref_mhz_r < REF_BAND2_MIN) ref_sel = 3'd1;
    else if (ref_mhz_r >= REF_BAND2_MIN && ref_mhz_r < REF_BAND3_MIN) ref_sel = 3'd2;
    else if (ref_mhz_r >= REF_BAND3_MIN && ref_mhz_r < REF_BAND4_MIN) ref_sel = 3'd3;
    else if (ref_mhz_r >= REF_BAND4_MIN && ref_mhz_r <= REF_BAND4_MAX) ref_sel = 3'd4;
    else band_ok = 1'b0;
  end

  assign vco = {4'h0, dac_mhz_r} << (lo_sel + 3'd1);
  // data rate in MHz times 20*M/L gives Mbps
  assign lane_prod = 26'((({12'h000, dac_mhz_r} >> interp_r) * LANE_RATE_MUL) * m_v);
  assign lane_rate = lane_prod / {22'h0, l_v};
  assign k_v = (k_short_r && mode_r != 4'd4 && mode_r != 4'd9) ? K_SHORT : K_LONG;
  assign k_ok = 1'b1;
  assign hd_v = (f_v == 4'd1);

  // feedback count: floor(dac / (2*ref/2^ref_sel)) by restoring division
  logic [FREQ_W+4:0] num_r;
  logic [FREQ_W+4:0] den_r;
  logic [FREQ_W+4:0] rem_r;
  logic [7:0] quo_r;
  logic [4:0] step_r;

  typedef enum {IDLE, DIVIDE, FINISH} calc_st_t;
  calc_st_t st_r;
  calc_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      IDLE: if (start) st_nxt = DIVIDE;
      DIVIDE: if (step_r == 5'd0) st_nxt = FINISH;
      FINISH: st_nxt = IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) st_r <= IDLE;
    else st_r <= st_nxt;
  end

  // dac*2^ref_sel / (2*ref): quotient over 8 bits, saturating flagged below
  always_ff @(posedge mclk) begin
    if (rst) begin
      num_r <= '0;
      den_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      step_r <= '0;
    end else if (st_r == IDLE && start) begin
      num_r <= {5'h00, dac_mhz_r} << ref_sel;
      den_r <= {4'h0, ref_mhz_r, 1'b0};
      rem_r <= '0;
      quo_r <= '0;
      step_r <= 5'd18;
    end else if (st_r == DIVIDE) begin
      // saturation is sticky: a quotient bit of weight 256 or more would otherwise shift out
      if ({rem_r[FREQ_W+3:0], num_r[FREQ_W+4]} >= den_r) begin
        rem_r <= {rem_r[FREQ_W+3:0], num_r[FREQ_W+4]} - den_r;
        quo_r <= (step_r >= 5'd8 || quo_r[7]) ? 8'hff : {quo_r[6:0], 1'b1};
      end else begin
        rem_r <= {rem_r[FREQ_W+3:0], num_r[FREQ_W+4]};
        quo_r <= quo_r[7] ? 8'hff : {quo_r[6:0], 1'b0};
      end
      num_r <= {num_r[FREQ_W+3:0], 1'b0};
      if (step_r != 5'd0) step_r <= step_r - 5'd1;
    end
  end

  // ----------------------------------------
  // checksum
  // ----------------------------------------
  function automatic logic [7:0] field_sum(input logic [3:0] l, input logic [3:0] m, input logic [5:0] k,
                                           input logic [3:0] s, input logic scr, input logic hd,
                                           input logic sub, input logic [2:0] ver);
    field_sum = 8'(l - 4'd1) + 8'(m - 4'd1) + 8'(k - 6'd1) + 8'(SAMPLE_BITS - 5'd1) * 8'd2
              + 8'(s - 4'd1) + {7'h0, scr} + {7'h0, hd} + {7'h0, sub} + {5'h0, ver};
  endfunction : field_sum

  // packed layout of the lane-zero configuration table, index 0 at CFG_REG_FIRST
  function automatic logic [7:0] cfg_reg(input logic [3:0] idx, input logic [3:0] l, input logic [3:0] m,
                                         input logic [5:0] k, input logic [3:0] s, input logic [3:0] f,
                                         input logic scr, input logic hd, input logic sub,
                                         input logic [2:0] ver);
    unique case (idx)
      4'd3: cfg_reg = {scr, 2'b00, 5'(l - 4'd1)};
      4'd4: cfg_reg = 8'(f - 4'd1);
      4'd5: cfg_reg = {3'b000, 5'(k - 6'd1)};
      4'd6: cfg_reg = 8'(m - 4'd1);
      4'd7: cfg_reg = {3'b000, 5'(SAMPLE_BITS - 5'd1)};
      4'd8: cfg_reg = {2'b00, sub, 5'(SAMPLE_BITS - 5'd1)};
      4'd9: cfg_reg = {ver, 5'(s - 4'd1)};
      4'd10: cfg_reg = {hd, 7'h00};
      default: cfg_reg = 8'h00;
    endcase
  endfunction : cfg_reg

  logic [7:0] reg_sum;
  always_comb begin
    reg_sum = 8'h00;
    for (int i = 0; i <= int'(CFG_REG_LAST - CFG_REG_FIRST); i++) begin
      reg_sum = reg_sum + cfg_reg(4'(i), l_v, m_v, k_v, s_v, f_v, scramble_r, hd_v, subclass_r, version_r);
    end
  end

  logic [7:0] checksum_v;
  assign checksum_v = checksum_method_r ? reg_sum
                    : field_sum(l_v, m_v, k_v, s_v, scramble_r, hd_v, subclass_r, version_r);

  // ----------------------------------------
  // result capture
  // ----------------------------------------
  logic ok;
  assign ok = mode_ok && band_ok && k_ok
           && vco >= {4'h0, VCO_MIN} && vco <= {4'h0, VCO_MAX}
           && quo_r >= FB_MIN && quo_r <= FB_MAX
           && lane_rate >= {8'h00, LANE_MIN} && lane_rate <= {8'h00, LANE_MAX};

  always_ff @(posedge mclk) begin
    if (rst) begin
      done <= 1'b0;
      cfg_error <= 1'b0;
      setup <= '0;
    end else begin
      done <= (st_r == FINISH);
      if (st_r == FINISH) begin
        cfg_error <= !ok;
        if (ok) begin
          setup.lo_sel <= lo_sel;
          setup.ref_sel <= ref_sel;
          setup.feedback <= quo_r;
          setup.interp <= interp_r;
          setup.lane_en <= 4'((5'd1 << l_v) - 5'd1);
          setup.lane_off <= ~phys_map_r;
          setup.checksum <= checksum_v;
          setup.conv_pd <= (m_v == 4'd2) ? 2'b00 : (keep_q_r ? 2'b10 : 2'b01);
          setup.clk_pd <= (m_v == 4'd2) ? 2'b00 : (keep_q_r ? 2'b10 : 2'b01);
          if (lane_rate <= {8'h00, CDR_BAND1_MAX}) begin
            setup.cdr_rate <= 1'b0;
            setup.cdr_ovs <= 1'b1;
            setup.pll_div <= 2'd2;
          end else if (lane_rate <= {8'h00, CDR_BAND2_MAX}) begin
            setup.cdr_rate <= 1'b0;
            setup.cdr_ovs <= 1'b0;
            setup.pll_div <= 2'd1;
          end else begin
            setup.cdr_rate <= 1'b1;
            setup.cdr_ovs <= 1'b0;
            setup.pll_div <= 2'd0;
          end
          setup.hd <= hd_v;
          setup.k <= k_v;
          setup.m <= m_v;
          setup.l <= l_v;
          setup.s <= s_v;
          setup.f <= f_v;
        end
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) rdata <= '0;
    else if (req.rd) begin
      unique case (req.addr)
        OUT_DIV_ADDR: rdata <= {29'h0, setup.lo_sel};
        REF_DIV_ADDR: rdata <= {29'h0, setup.ref_sel};
        LANE_OFF_ADDR: rdata <= {28'h0, setup.lane_off};
        SERDES_PLL_ADDR: rdata <= {24'h0, SERDES_PLL_FIXED | {6'h00, setup.pll_div}};
        STATUS_ADDR: rdata <= {29'h0, st_r != IDLE, cfg_error, done};
        FREQ_DAC_ADDR: rdata <= {18'h0, dac_mhz_r};
        FREQ_REF_ADDR: rdata <= {18'h0, ref_mhz_r};
        LINK_ADDR: rdata <= {12'h0, phys_map_r, 2'b00, version_r, keep_q_r, checksum_method_r,
                             subclass_r, scramble_r, k_short_r, interp_r, mode_r};
        FEEDBACK_ADDR: rdata <= {24'h0, setup.feedback};
        PARAMS_ADDR: rdata <= {7'h0, setup.hd, 2'b00, setup.k, setup.m, setup.l, setup.s, setup.f};
        CHECKSUM_ADDR: rdata <= {24'h0, setup.checksum};
        POWER_ADDR: rdata <= {26'h0, setup.cdr_rate, setup.cdr_ovs, setup.clk_pd, setup.conv_pd};
        LANES_ADDR: rdata <= {28'h0, setup.lane_en};
        default: rdata <= '0;
      endcase
    end else rdata <= '0;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_start;
    st_r == IDLE && start;
  endsequence
  // done is registered off the FINISH state, so the checker sees it one edge after the state
  sequence s_done;
    ##21 done;
  endsequence
  sequence s_result;
    done && !cfg_error;
  endsequence

  AST_DONE_LATENCY: assert property (@(posedge mclk) disable iff (rst) s_start |-> s_done)
    else $error("done not 20 cycles after start");
  AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (rst) done |=> !done)
    else $error("done longer than one cycle");
  AST_HD: assert property (@(posedge mclk) disable iff (rst) done && !cfg_error |-> setup.hd == (setup.f == 4'd1))
    else $error("hd mismatch");
  AST_LANE_EN: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error |-> setup.lane_en == 4'((5'd1 << setup.l) - 5'd1))
    else $error("lane enable not thermometer");
  AST_FB_RANGE: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error |-> setup.feedback >= 8'd6 && setup.feedback <= 8'd127)
    else $error("feedback count out of range");
  AST_K_FIXED: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error && setup.l == 4'd4 && setup.s == 4'd1 |-> setup.k == 6'd32)
    else $error("k must be 32 in mode 4");
  AST_K_MODE9: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error && setup.m == 4'd1 && setup.l == 4'd2 |-> setup.k == K_LONG)
    else $error("k must be 32 in mode 9");
  AST_PD_PAIR: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error |-> (setup.m == 4'd2) == (setup.conv_pd == 2'b00))
    else $error("power-down disagrees with m");
  AST_CLK_PD: assert property (@(posedge mclk) disable iff (rst)
    s_result |-> setup.clk_pd == setup.conv_pd)
    else $error("clock power-down disagrees with converter power-down");
  AST_CDR: assert property (@(posedge mclk) disable iff (rst)
    done && !cfg_error && setup.cdr_rate |-> setup.pll_div == 2'd0 && !setup.cdr_ovs)
    else $error("cdr setting inconsistent");
  AST_CDR_LOW: assert property (@(posedge mclk) disable iff (rst)
    s_result and setup.cdr_ovs |-> setup.pll_div == 2'd2 && !setup.cdr_rate)
    else $error("low band cdr setting inconsistent");
  AST_PLL_READ: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.addr == SERDES_PLL_ADDR |=> rdata[1:0] == $past(setup.pll_div))
    else $error("pll divide not in low bits of read-back");
  AST_HOLD_ON_ERR: assert property (@(posedge mclk) disable iff (rst)
    done && cfg_error |-> $stable(setup))
    else $error("outputs changed on error");
endmodule : dac_link_setup_calc

/* File: sim/link_tx_model.sv */
`timescale 1ns/10ps
// ----
// far-side transmitter link configuration
// ----
module link_tx_model (
  input wire logic [3:0] mode,
  input wire logic k_short,
  input wire logic scr,
  input wire logic sub,
  input wire logic [2:0] ver,
  input wire logic meth,
  output logic [3:0] m,
  output logic [3:0] l,
  output logic [3:0] s,
  output logic [3:0] f,
  output logic [5:0] k,
  output logic hd,
  output logic [7:0] sum,
  output logic ok
);
  // the transmitter holds its own copy; the receiver has to agree with it
  always_comb begin
    ok = 1'b1;
    case (mode)
      4'd4: {m, l, s, f} = {4'd2, 4'd4, 4'd1, 4'd1};
      4'd5: {m, l, s, f} = {4'd2, 4'd4, 4'd2, 4'd2};
      4'd6: {m, l, s, f} = {4'd2, 4'd2, 4'd1, 4'd2};
      4'd7: {m, l, s, f} = {4'd2, 4'd1, 4'd1, 4'd4};
      4'd9: {m, l, s, f} = {4'd1, 4'd2, 4'd1, 4'd1};
      4'd10: {m, l, s, f} = {4'd1, 4'd1, 4'd1, 4'd2};
      default: begin
        {m, l, s, f} = '0;
        ok = 1'b0;
      end
    endcase
    hd = (f == 4'd1);
    k = (k_short && mode != 4'd4 && mode != 4'd9) ? 6'd16 : 6'd32;
    // field sum with n and np fixed at 16; only link zero exists here
    // the register method sums the packed table: scr/hd at bit 7, sub/ver at bit 5
    sum = meth ? 8'(int'(l) + f + k + m + s + 25 + 128 * (scr + hd) + 32 * (sub + ver))
               : 8'(int'(l) + m + k + s + 26 + scr + hd + sub + ver);
  end
endmodule : link_tx_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import link_setup_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [31:0] rdata;
  logic done, cfg_error;
  setup_t setup;
  setup_t exp_r = '0;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'hd59b41d1;
  int modes[6] = '{4, 5, 6, 7, 9, 10};
  logic [3:0] tx_mode = 4'h4;
  logic tx_kshort = 1'b0, tx_scr = 1'b0, tx_sub = 1'b0, tx_meth = 1'b0;
  logic [2:0] tx_ver = 3'h1;
  logic [3:0] tx_m, tx_l, tx_s, tx_f;
  logic [5:0] tx_k;
  logic tx_hd, tx_ok;
  logic [7:0] tx_sum;

  always #20 mclk = ~mclk;

  dac_link_setup_calc dut_u (
    .mclk(mclk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .done(done),
    .cfg_error(cfg_error),
    .setup(setup)
  );

  link_tx_model tx_u (
    .mode(tx_mode),
    .k_short(tx_kshort),
    .scr(tx_scr),
    .sub(tx_sub),
    .ver(tx_ver),
    .meth(tx_meth),
    .m(tx_m),
    .l(tx_l),
    .s(tx_s),
    .f(tx_f),
    .k(tx_k),
    .hd(tx_hd),
    .sum(tx_sum),
    .ok(tx_ok)
  );

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] expv);
    num_checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  // one strobe cycle, then a gap cycle so no signal is driven twice in a step
  task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
    q = rdata;
  endtask : bus

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // ----
  // one derivation against the reference model
  // ----
  task automatic run(input int fdac, input int fref, input logic [31:0] link, input logic dbl);
    int lo, rf, fb, lane, n, extra;
    logic [31:0] q;
    logic err;
    setup_t e;
    setup_t s;
    bus(FREQ_DAC_ADDR, fdac, 1'b1, q);
    bus(FREQ_REF_ADDR, fref, 1'b1, q);
    bus(LINK_ADDR, link, 1'b1, q);
    tx_mode = link[3:0];
    tx_kshort = link[6];
    tx_scr = link[7];
    tx_sub = link[8];
    tx_ver = link[13:11];
    tx_meth = link[9];
    #1;
    lo = (fdac >= 1500) ? 1 : (fdac >= 750) ? 2 : (fdac >= 420) ? 3 : 0;
    rf = (fref >= 640) ? 4 : (fref >= 320) ? 3 : (fref >= 160) ? 2 : (fref >= 80) ? 1 : 0;
    fb = (fdac << rf) / (2 * fref);
    lane = tx_ok ? 20 * (fdac >> link[5:4]) * tx_m / tx_l : 0;
    err = lo == 0 || rf == 0 || fdac > 2250 || fref > 1000 || !tx_ok || (fdac << (lo + 1)) < 6000;
    err = err || (fdac << (lo + 1)) > 12000 || fb < 6 || fb > 127 || lane < 1440 || lane > 12380;
    e = exp_r;
    if (!err) begin
      e.lo_sel = 3'(lo);
      e.ref_sel = 3'(rf);
      e.feedback = 8'(fb);
      e.interp = link[5:4];
      e.lane_en = 4'((1 << tx_l) - 1);
      e.lane_off = ~link[19:16];
      e.checksum = tx_sum;
      e.conv_pd = (tx_m == 4'd2) ? 2'b00 : link[10] ? 2'b10 : 2'b01;
      e.clk_pd = e.conv_pd;
      {e.cdr_rate, e.cdr_ovs, e.pll_div} = (lane <= 3090) ? 4'b0110 : (lane <= 6190) ? 4'b0001 : 4'b1000;
      e.hd = tx_hd;
      e.k = tx_k;
      {e.m, e.l, e.s, e.f} = {tx_m, tx_l, tx_s, tx_f};
    end
    bus(CTRL_ADDR, 32'h1, 1'b1, q);
    n = 0;
    if (dbl) begin
      bus(CTRL_ADDR, 32'h1, 1'b1, q);
      bus(STATUS_ADDR, 32'h0, 1'b0, q);
      check("busy", q[2], 1'b1);
      n = 4;
    end
    while (done !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("done_time", n, 20);
    exp_r = e;
    s = setup;
    check("cfg_error", cfg_error, err);
    check("setup", s, exp_r);
    extra = 0;
    repeat (24) begin
      @(posedge mclk);
      #1;
      extra += (done !== 1'b0);
    end
    check("done_count", extra, 0);
    bus(OUT_DIV_ADDR, 32'h0, 1'b0, q);
    check("out_div", q, exp_r.lo_sel);
    bus(REF_DIV_ADDR, 32'h0, 1'b0, q);
    check("ref_div", q, exp_r.ref_sel);
    bus(LANE_OFF_ADDR, 32'h0, 1'b0, q);
    check("lane_off", q, exp_r.lane_off);
    bus(SERDES_PLL_ADDR, 32'h0, 1'b0, q);
    check("serdes_pll", q, SERDES_PLL_FIXED | 8'(exp_r.pll_div));
    bus(FEEDBACK_ADDR, 32'h0, 1'b0, q);
    check("feedback", q, exp_r.feedback);
    bus(CHECKSUM_ADDR, 32'h0, 1'b0, q);
    check("checksum", q, exp_r.checksum);
    bus(POWER_ADDR, 32'h0, 1'b0, q);
    check("power", q, {exp_r.cdr_rate, exp_r.cdr_ovs, exp_r.clk_pd, exp_r.conv_pd});
    bus(STATUS_ADDR, 32'h0, 1'b0, q);
    check("status", q, {err, 1'b0});
  endtask : run

  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] q;
    int mi;
    logic [31:0] link;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("reset", {done, cfg_error, setup}, 96'h0);
    run(2000, 250, 32'h000f09a4, 1'b1);
    run(1000, 100, 32'h00050216, 1'b0);
    run(800, 800, 32'h0001047a, 1'b0);
    run(1600, 80, 32'h00030079, 1'b0);
    run(1500, 160, 32'h000f3855, 1'b0);
    run(600, 960, 32'h00010037, 1'b0);
    run(400, 100, 32'h000f0004, 1'b0);
    run(2000, 250, 32'h00010007, 1'b0);
    run(2000, 250, 32'h000f0028, 1'b0);
    run(2000, 1100, 32'h000f09a4, 1'b0);
    repeat (30) begin
      mi = ($random(seed) & 32'h7fff) % 6;
      link = ($random(seed) & 32'h000f3ff0) | modes[mi];
      run(424 + ($random(seed) & 32'h7fff) % 229 * 8, 80 + ($random(seed) & 32'h7fff) % 921, link, 1'b0);
    end
    bus(12'h7fe, 32'h5a, 1'b1, q);
    bus(12'h7fe, 32'h0, 1'b0, q);
    check("unmapped", q, 32'h0);
    bus(OUT_DIV_ADDR, 32'h3, 1'b1, q);
    bus(OUT_DIV_ADDR, 32'h0, 1'b0, q);
    check("read_only", q, exp_r.lo_sel);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("reset_again", {done, cfg_error, setup}, 96'h0);
    bus(OUT_DIV_ADDR, 32'h0, 1'b0, q);
    check("out_div_reset", q, 32'h0);
    summarize();
  end

  // a hung handshake ends the run as a failure
  initial begin
    #(40 * 20000);
    num_errors++;
    summarize();
  end
endmodule : tb_top
